// ==== dv/loop_watchdog_sva.sv ====
// Port assertions for the loop-detect watchdog
`timescale 1ns/1ns
module loop_watchdog_sva
    import loop_watchdog_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_bit_access,
    input wire logic [7:0] bus_wdata,
    input wire logic internal_reset,
    input wire logic dog_reset_cause_flag,
    input wire logic [7:0] watchdog_mode_config
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Stop bit set by the first write silences every misuse reset
    wire st = watchdog_mode_config[CLK_STOP_BIT];
    wire kw = bus_wr && bus_addr == CLEAR_KEY_ADDR;
    wire mw = bus_wr && bus_addr == MODE_CONFIG_ADDR;
    property p_bad; kw && !st && bus_wdata != CLEAR_KEY_VALUE |=> internal_reset; endproperty
    a_bad: assert property (p_bad) else $error("bad key");
    property p_bit; kw && !st && bus_bit_access |=> internal_reset; endproperty
    a_bit: assert property (p_bit) else $error("bit key");
    property p_good; kw && bus_wdata == CLEAR_KEY_VALUE && !bus_bit_access |=> !internal_reset;
    endproperty
    a_good: assert property (p_good) else $error("good key");
    property p_quiet; kw && st |=> !internal_reset; endproperty
    a_quiet: assert property (p_quiet) else $error("quiet");
    property p_pulse; internal_reset |=> !internal_reset; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse");
    property p_flag; internal_reset |-> dog_reset_cause_flag ##1 dog_reset_cause_flag; endproperty
    a_flag: assert property (p_flag) else $error("flag");
    property p_upper; watchdog_mode_config[7:5] == 3'h3; endproperty
    a_upper: assert property (p_upper) else $error("upper");
    property p_once; !mw |=> $stable(watchdog_mode_config); endproperty
    a_once: assert property (p_once) else $error("mode moved");
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the loop-detect watchdog
`timescale 1ns/1ns
module tb_top;
    import loop_watchdog_pkg::*;
    logic core_clk = 0, arst_n = 0, low_speed_osc_clock = 0, osc_unstoppable = 0;
    logic bus_wr = 0, bus_rd = 0, bus_bit_access = 0, internal_reset, dog_reset_cause_flag, hit;
    logic [15:0] bus_addr = 16'h0000;
    logic [7:0] bus_wdata = 8'h00, bus_rdata, watchdog_mode_config;
    int seed = 79, bad_count = 0, checks_done = 0, cycles = 0, n;
    loop_watchdog dut_u (.core_clk, .arst_n, .low_speed_osc_clock, .osc_unstoppable, .bus_addr,
        .bus_wr, .bus_rd, .bus_bit_access, .bus_wdata, .bus_rdata, .internal_reset,
        .dog_reset_cause_flag, .watchdog_mode_config);
    always #50 core_clk = ~core_clk;
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        if (bad_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Ceiling leaves room for one system-clock overflow of 8192 cycles
    always @(posedge core_clk) begin
        cycles++;
        low_speed_osc_clock <= cycles[3];
        if (cycles == 30000) begin
            bad_count++;
            complete_run;
        end
    end
    task automatic rst(logic keep);
        arst_n <= 0;
        osc_unstoppable <= keep;
        repeat (5) @(posedge core_clk);
        arst_n <= 1;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic put(logic [15:0] a, logic [7:0] d, logic b);
        @(posedge core_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_bit_access <= b;
        bus_wr <= 1;
        @(posedge core_clk);
        bus_wr <= 0;
        #1 hit = internal_reset;
    endtask
    task automatic get(logic [15:0] a, logic [7:0] exp);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd <= 1;
        @(posedge core_clk);
        bus_rd <= 0;
        #1 chk("read", bus_rdata, exp);
    endtask
    initial begin
        rst(0);
        chk("flag idle", dog_reset_cause_flag, 8'h00);
        get(CLEAR_KEY_ADDR, CLEAR_KEY_READ);
        get(MODE_CONFIG_ADDR, MODE_CONFIG_RESET);
        for (int i = 0; i < 6; i++) begin
            n = $random(seed);
            put(CLEAR_KEY_ADDR, n[7:0] ^ {7'h00, n[7:0] == CLEAR_KEY_VALUE}, n[8]);
            chk("bad key", hit, 8'h01);
        end
        put(CLEAR_KEY_ADDR, CLEAR_KEY_VALUE, 1);
        chk("bit key", hit, 8'h01);
        rst(0);
        put(MODE_CONFIG_ADDR, 8'h68, 0);
        chk("mode", watchdog_mode_config, 8'h68);
        repeat (4000) @(posedge core_clk);
        put(CLEAR_KEY_ADDR, CLEAR_KEY_VALUE, 0);
        for (n = 1; internal_reset !== 1 && n < 9000; n++) #100;
        chk("overflow", n > 8189 && n < 8197, 8'h01);
        chk("flag", dog_reset_cause_flag, 8'h01);
        n = $random(seed);
        put(MODE_CONFIG_ADDR, {3'h3, n[4:0]}, 0);
        chk("rewrite", hit, 8'h01);
        chk("kept", watchdog_mode_config, 8'h68);
        rst(0);
        put(MODE_CONFIG_ADDR, 8'h70, 0);
        put(MODE_CONFIG_ADDR, 8'h68, 0);
        chk("stop rewrite", hit, 8'h00);
        put(CLEAR_KEY_ADDR, 8'h55, 1);
        chk("stop key", hit, 8'h00);
        chk("stopped", watchdog_mode_config, 8'h70);
        rst(1);
        put(MODE_CONFIG_ADDR, 8'h78, 0);
        chk("fixed", watchdog_mode_config, 8'h60);
        put(CLEAR_KEY_ADDR, 8'h55, 0);
        chk("no stop", hit, 8'h01);
        complete_run;
    end
endmodule
bind loop_watchdog loop_watchdog_sva sva_u (.core_clk, .arst_n, .bus_addr, .bus_wr,
    .bus_bit_access, .bus_wdata, .internal_reset, .dog_reset_cause_flag, .watchdog_mode_config);

// ==== rtl/loop_watchdog.sv ====
// Loop-detect watchdog with write-once mode register and key-cleared counter
`timescale 1ns/1ns
// Contract
// - Mode register writable once; repeat resets
// - Mode register resets to 0x67
// - Clock select: 00 slow, 01 system, 1x stop
// - Overflow after 2^(11+n) or 2^(13+n) ticks
// - Unstoppable option forces slow clock source
// - Overflow code starts at 111
// - Stopped by first write suppresses misuse resets
// - Key 0xAC clears and restarts counter
// - Wrong key generates internal reset
// - Bit access to key register resets
// - Key register always reads 0x9A
// - Overflow resets and sets cause flag bit 4
// - Mode write clears the counter
// - Unstoppable option never lets watchdog stop
module loop_watchdog
    import loop_watchdog_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic low_speed_osc_clock,
    input wire logic osc_unstoppable,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_bit_access,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic internal_reset,
    output logic dog_reset_cause_flag,
    output logic [7:0] watchdog_mode_config
);
    // Lock state of the mode register; the code 2'b11 is never entered
    typedef enum logic [1:0] {
        MODE_OPEN = 2'b00,
        MODE_LOCKED = 2'b01,
        MODE_STOPPED = 2'b10
    } mode_lock_t;

    logic rst_sync1;
    logic rst_n;
    logic slow_sync1;
    logic slow_sync2;
    logic slow_prev;
    logic slow_edge;
    logic opt_sync1;
    logic opt_sync2;
    mode_lock_t lock_state;
    mode_lock_t next_lock_state;
    logic mode_wr;
    logic key_wr;
    logic key_good;
    logic stop_request;
    logic misuse;
    logic reset_request;
    logic use_system;
    logic running;

    loop_watchdog_tick_if link ();

    // Reset asserts at once but releases through two flops, clean against the clock
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_sync1 <= 1'b1;
            rst_n <= rst_sync1;
        end
    end

    // Slow oscillator is asynchronous; sample it and take rising edges as ticks
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_sync1 <= 1'b0;
            slow_sync2 <= 1'b0;
            slow_prev <= 1'b0;
        end else begin
            slow_sync1 <= low_speed_osc_clock;
            slow_sync2 <= slow_sync1;
            slow_prev <= slow_sync2;
        end
    end

    assign slow_edge = slow_sync2 && !slow_prev;

    // The option level is static in practice but still crosses into this clock;
    // it runs through its flops during reset, so it needs no reset of its own
    always_ff @(posedge core_clk) begin
        opt_sync1 <= osc_unstoppable;
        opt_sync2 <= opt_sync1;
    end

    assign mode_wr = bus_wr && (bus_addr == MODE_CONFIG_ADDR);
    assign key_wr = bus_wr && (bus_addr == CLEAR_KEY_ADDR);
    assign key_good = !bus_bit_access && (bus_wdata == CLEAR_KEY_VALUE);
    // A first write may only stop the dog when the slow oscillator may stop too
    assign stop_request = !opt_sync2 && !bus_bit_access && bus_wdata[CLK_STOP_BIT];
    assign use_system = !opt_sync2 && watchdog_mode_config[CLK_SOURCE_BIT];
    assign running = opt_sync2 || !watchdog_mode_config[CLK_STOP_BIT];

    // The first mode write locks the register for good; a bit access still
    // uses up that write, so software cannot retry with a proper byte write
    always_comb begin
        next_lock_state = lock_state;
        unique case (lock_state)
            MODE_OPEN: begin
                if (mode_wr && stop_request) begin
                    next_lock_state = MODE_STOPPED;
                end else if (mode_wr) begin
                    next_lock_state = MODE_LOCKED;
                end
            end
            MODE_LOCKED: begin
                next_lock_state = MODE_LOCKED;
            end
            MODE_STOPPED: begin
                next_lock_state = MODE_STOPPED;
            end
            default: begin
                next_lock_state = MODE_LOCKED;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_state <= MODE_OPEN;
        end else begin
            lock_state <= next_lock_state;
        end
    end

    // Misuse only counts while the watchdog has not been stopped by software
    always_comb begin
        misuse = 1'b0;
        if (lock_state != MODE_STOPPED) begin
            if (mode_wr && lock_state != MODE_OPEN) begin
                misuse = 1'b1;
            end
            if (key_wr && bus_bit_access) begin
                misuse = 1'b1;
            end
            if (key_wr && !bus_bit_access && !key_good) begin
                misuse = 1'b1;
            end
        end
    end
    assign reset_request = misuse || link.overflow;

    // Upper bits keep their fixed pattern whatever software writes there
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_mode_config <= MODE_CONFIG_RESET;
        end else if (mode_wr && lock_state == MODE_OPEN && !bus_bit_access) begin
            watchdog_mode_config[7:5] <= MODE_CONFIG_RESET[7:5];
            watchdog_mode_config[2:0] <= bus_wdata[2:0];
            if (!opt_sync2) begin
                watchdog_mode_config[4:3] <= bus_wdata[4:3];
            end
        end
    end

    // The system clock ticks every cycle; the slow source once per rising edge
    always_comb begin
        link.tick = running && (use_system || slow_edge);
        link.overflow_code = watchdog_mode_config[OVERFLOW_CODE_LSB +: OVERFLOW_CODE_WIDTH];
        link.use_system = use_system;
        link.clear = mode_wr || (key_wr && !bus_bit_access
            && bus_wdata == CLEAR_KEY_VALUE);
    end

    // A clear in the same cycle as a tick wins, so a timely key never overflows
    loop_watchdog_counter u_counter (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .link(link)
    );

    // Reset request is a one-cycle pulse; the system reset returns it here
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            internal_reset <= 1'b0;
        end else begin
            internal_reset <= reset_request;
        end
    end

    // Cause flag outlives the reset pulse; only a chip reset clears it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dog_reset_cause_flag <= 1'b0;
        end else if (reset_request) begin
            dog_reset_cause_flag <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata <= 8'h00;
        end else if (bus_rd) begin
            case (bus_addr)
                MODE_CONFIG_ADDR: begin
                    bus_rdata <= watchdog_mode_config;
                end
                CLEAR_KEY_ADDR: begin
                    bus_rdata <= CLEAR_KEY_READ;
                end
                default: begin
                    bus_rdata <= 8'h00;
                end
            endcase
        end else begin
            bus_rdata <= 8'h00;
        end
    end
endmodule

// ==== rtl/loop_watchdog_counter.sv ====
// Overflow counter of the loop-detect watchdog
`timescale 1ns/1ns
module loop_watchdog_counter
    import loop_watchdog_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    loop_watchdog_tick_if.counter link
);
    logic [COUNTER_WIDTH-1:0] count;
    logic [4:0] exp_sel;
    logic [COUNTER_WIDTH-1:0] limit;

    always_comb begin
        exp_sel = 5'(link.use_system ? SYSTEM_BASE_EXP : LOW_SPEED_BASE_EXP)
            + 5'(link.overflow_code);
        limit = COUNTER_WIDTH'((22'(1) << exp_sel) - 22'(1));
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (link.clear) begin
            count <= '0;
        end else if (link.tick) begin
            count <= (count >= limit) ? '0 : count + COUNTER_WIDTH'(1);
        end
    end

    // Overflow on the tick that would pass the limit
    assign link.overflow = link.tick && !link.clear && (count >= limit);
endmodule

// ==== rtl/loop_watchdog_pkg.sv ====
// Constants for the loop-detect watchdog
package loop_watchdog_pkg;
    localparam logic [15:0] MODE_CONFIG_ADDR = 16'hFF48;
    localparam logic [15:0] CLEAR_KEY_ADDR = 16'hFF49;
    localparam logic [7:0] MODE_CONFIG_RESET = 8'h67;
    localparam logic [7:0] CLEAR_KEY_READ = 8'h9A;
    localparam logic [7:0] CLEAR_KEY_VALUE = 8'hAC;
    localparam int CLK_STOP_BIT = 4;
    localparam int CLK_SOURCE_BIT = 3;
    localparam int OVERFLOW_CODE_LSB = 0;
    localparam int OVERFLOW_CODE_WIDTH = 3;
    localparam int LOW_SPEED_BASE_EXP = 11;
    localparam int SYSTEM_BASE_EXP = 13;
    localparam int COUNTER_WIDTH = 21;
    localparam int DOG_CAUSE_BIT = 4;
    localparam logic [7:0] CAUSE_FLAG_MASK = 8'h10;
endpackage

// ==== rtl/loop_watchdog_tick_if.sv ====
// Count-source tick and clear carrier between the watchdog and its counter
`timescale 1ns/1ns
interface loop_watchdog_tick_if;
    logic tick;
    logic clear;
    logic [2:0] overflow_code;
    logic use_system;
    logic overflow;
    modport ctrl (output tick, output clear, output overflow_code, output use_system,
        input overflow);
    modport counter (input tick, input clear, input overflow_code, input use_system,
        output overflow);
endinterface
